/* File: hdl/ccp_pkg.sv */
// Shared constants for the command client port
package ccp_pkg;
  // Default 7-bit bus address and read/write bit
  localparam logic [6:0] BUS_ADDR_DFLT = 7'h38;
  localparam logic       RW_WRITE      = 1'h0;
  // Word address functions
  localparam logic [7:0] WA_RESET  = 8'h00;
  localparam logic [7:0] WA_SLEEP  = 8'h01;
  localparam logic [7:0] WA_IDLE   = 8'h02;
  localparam logic [7:0] WA_CMD    = 8'h03;
  localparam logic [7:0] WA_LAST   = 8'h03;
  // Bit positions within a byte slot
  localparam logic [3:0] BIT_LAST  = 4'h8;
  localparam logic [3:0] BIT_ACK   = 4'h9;
  // Timing in microseconds and clock rate
  localparam int CLK_MHZ            = 100;
  localparam int WAKE_LOW_TIME_US   = 60;
  localparam int WAKE_HIGH_DELAY_US = 1500;
  localparam int WAKE_LOW_CYC       = WAKE_LOW_TIME_US * CLK_MHZ;
  localparam int WAKE_HIGH_CYC      = WAKE_HIGH_DELAY_US * CLK_MHZ;
  // Input buffer and filter sizes
  localparam int BUF_DEPTH_DFLT     = 128;
  localparam int FILT_CYC_DFLT      = 4;
  // Device modes and bus states
  typedef enum logic [2:0] {M_SLEEP, M_WAKE, M_AWAKE, M_IDLE, M_BUSY} ccp_mode_t;
  typedef enum logic [2:0] {B_FREE, B_ADDR, B_WORD, B_DATA, B_SKIP} ccp_bus_t;
endpackage : ccp_pkg

/* File: hdl/ccp_filter.sv */
// Two-flop synchroniser with glitch filter for one bus pin
`timescale 1ns/1ps
module ccp_filter #(
  parameter int FILT_CYC = 4,
  parameter bit INIT     = 1'b1
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  // Pin in, filtered level out
  input  wire logic PIN,
  output logic      LEVEL
);
  localparam int CW = $clog2(FILT_CYC + 1);

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] stable_cnt;
  wire           differs = (sync_b != LEVEL);
  wire           settled = (stable_cnt == CW'(FILT_CYC));

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_a     <= INIT;
      sync_b     <= INIT;
      stable_cnt <= '0;
      LEVEL      <= INIT;
    end else begin
      sync_a <= PIN;
      sync_b <= sync_a;
      // Accept a new level only after it holds for the filter length
      if (!differs) begin
        stable_cnt <= '0;
      end else if (settled) begin
        stable_cnt <= '0;
        LEVEL      <= sync_b;
      end else begin
        stable_cnt <= stable_cnt + CW'(1);
      end
    end
  end
endmodule : ccp_filter

/* File: hdl/ccp_port.sv */
// Two-wire command client port: bus conditions, address match, word decode, input FIFO
`timescale 1ns/1ps
module ccp_port #(
  parameter logic [6:0] BUS_ADDR      = ccp_pkg::BUS_ADDR_DFLT,
  parameter int         BUF_DEPTH     = ccp_pkg::BUF_DEPTH_DFLT,
  parameter int         FILT_CYC      = ccp_pkg::FILT_CYC_DFLT,
  parameter int         WAKE_LOW_CYC  = ccp_pkg::WAKE_LOW_CYC,
  parameter int         WAKE_HIGH_CYC = ccp_pkg::WAKE_HIGH_CYC
) (
  // System clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RESET_N,
  // Link clock (SCL pin) and data pin
  input  wire logic                         SCL,
  input  wire logic                         SDA_I,
  output logic                              SDA_O,
  output logic                              SDA_OE,
  // Command engine handshake
  output logic                              CMD_START,
  input  wire logic                         CMD_DONE,
  output logic                              SLEEP_REQ,
  output logic                              IDLE_REQ,
  // Input buffer read port
  input  wire logic [$clog2(BUF_DEPTH)-1:0] BUF_RD_ADDR,
  output logic      [7:0]                   BUF_RD_DATA,
  output logic      [7:0]                   BUF_FILL,
  // Mode status
  output logic                              ASLEEP,
  output logic                              IDLE,
  output logic                              BUSY
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int WL = $clog2(WAKE_LOW_CYC + 1);
  localparam int WH = $clog2(WAKE_HIGH_CYC + 1);

  // Link domain: byte shifted in on every SCL rise
  logic [7:0] link_byte;
  always_ff @(posedge SCL or negedge RESET_N) begin
    if (!RESET_N) begin
      link_byte <= 8'h00;
    end else begin
      link_byte <= {link_byte[6:0], SDA_I};
    end
  end

  logic sda_f;
  logic scl_f;
  ccp_filter #(.FILT_CYC(FILT_CYC), .INIT(1'b1)) u_sda_filt (
    .CLK    (CLK),
    .RESET_N(RESET_N),
    .PIN    (SDA_I),
    .LEVEL  (sda_f)
  );
  ccp_filter #(.FILT_CYC(FILT_CYC), .INIT(1'b1)) u_scl_filt (
    .CLK    (CLK),
    .RESET_N(RESET_N),
    .PIN    (SCL),
    .LEVEL  (scl_f)
  );

  logic sda_d;
  logic scl_d;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_d <= sda_f;
      scl_d <= scl_f;
    end
  end

  ccp_pkg::ccp_mode_t mode;
  ccp_pkg::ccp_mode_t next_mode;
  ccp_pkg::ccp_bus_t  bstate;
  ccp_pkg::ccp_bus_t  next_bstate;

  wire awake     = (mode == ccp_pkg::M_AWAKE);
  wire sda_rise  = sda_f && !sda_d;
  wire scl_rise  = scl_f && !scl_d;
  wire scl_fall  = !scl_f && scl_d;
  wire start_ev  = awake && scl_f && scl_d && !sda_f && sda_d;
  wire stop_ev   = awake && scl_f && scl_d && sda_f && !sda_d;

  // Byte slot tracking in the system domain
  logic [3:0] bit_cnt;
  logic       ack_drv;
  logic [7:0] word;
  logic       word_ok;
  wire byte_done = awake && scl_fall && (bit_cnt == ccp_pkg::BIT_LAST);
  wire slot_end  = awake && scl_fall && (bit_cnt == ccp_pkg::BIT_ACK);
  // Link byte is quiet from the eighth rise until the ninth
  wire [7:0] rx_byte = link_byte;

  // Input FIFO
  logic [7:0]  buf_mem [BUF_DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] next_wr_ptr;
  wire  [7:0]  count_byte = buf_mem[0];
  wire full_grp  = (wr_ptr != '0) && (wr_ptr >= (AW+1)'(count_byte));
  wire room      = (wr_ptr < (AW+1)'(BUF_DEPTH));
  wire partial   = (wr_ptr != '0) && !full_grp;

  wire addr_hit  = (rx_byte[7:1] == BUS_ADDR);
  wire is_write  = (rx_byte[0] == ccp_pkg::RW_WRITE);
  wire read_ok   = awake && !partial;
  wire word_lgl  = (rx_byte <= ccp_pkg::WA_LAST);
  wire store     = (bstate == ccp_pkg::B_DATA) && byte_done && (word == ccp_pkg::WA_CMD)
                   && !full_grp && room;

  // Acknowledge decision for the byte just received
  logic give_ack;
  always_comb begin
    give_ack    = 1'b0;
    next_bstate = bstate;
    unique case (bstate)
      ccp_pkg::B_FREE: next_bstate = ccp_pkg::B_FREE;
      ccp_pkg::B_ADDR: begin
        if (addr_hit && is_write) begin
          give_ack    = 1'b1;
          next_bstate = ccp_pkg::B_WORD;
        end else if (addr_hit && read_ok) begin
          give_ack    = 1'b1;
          next_bstate = ccp_pkg::B_SKIP;
        end else begin
          next_bstate = ccp_pkg::B_SKIP;
        end
      end
      ccp_pkg::B_WORD: begin
        give_ack    = word_lgl;
        next_bstate = word_lgl ? ccp_pkg::B_DATA : ccp_pkg::B_SKIP;
      end
      ccp_pkg::B_DATA: give_ack = 1'b1;
      ccp_pkg::B_SKIP: next_bstate = ccp_pkg::B_SKIP;
    endcase
  end

  // Bus state and bit counter
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bstate  <= ccp_pkg::B_FREE;
      bit_cnt <= 4'h0;
      ack_drv <= 1'b0;
      word    <= 8'h00;
      word_ok <= 1'b0;
    end else if (!awake || stop_ev) begin
      bstate  <= ccp_pkg::B_FREE;
      bit_cnt <= 4'h0;
      ack_drv <= 1'b0;
      word_ok <= 1'b0;
    end else if (start_ev) begin
      bstate  <= ccp_pkg::B_ADDR;
      bit_cnt <= 4'h0;
      ack_drv <= 1'b0;
      word_ok <= 1'b0;
    end else begin
      if (scl_rise && bit_cnt != ccp_pkg::BIT_ACK) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (byte_done) begin
        ack_drv <= give_ack && (bstate != ccp_pkg::B_FREE);
        bstate  <= next_bstate;
        if (bstate == ccp_pkg::B_WORD && word_lgl) begin
          word    <= rx_byte;
          word_ok <= 1'b1;
        end
      end
      if (slot_end) begin
        ack_drv <= 1'b0;
        bit_cnt <= 4'h0;
      end
    end
  end

  // Buffer pointer
  always_comb begin
    next_wr_ptr = wr_ptr;
    if (mode == ccp_pkg::M_SLEEP) begin
      next_wr_ptr = '0;
    end else if (mode == ccp_pkg::M_BUSY && CMD_DONE) begin
      next_wr_ptr = '0;
    end else if (byte_done && bstate == ccp_pkg::B_WORD && rx_byte == ccp_pkg::WA_RESET) begin
      next_wr_ptr = '0;
    end else if (store) begin
      next_wr_ptr = wr_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
    end
  end

  always_ff @(posedge CLK) begin
    if (store) begin
      buf_mem[wr_ptr[AW-1:0]] <= rx_byte;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUF_RD_DATA <= 8'h00;
      BUF_FILL    <= 8'h00;
    end else begin
      BUF_RD_DATA <= buf_mem[BUF_RD_ADDR];
      BUF_FILL    <= 8'(wr_ptr);
    end
  end

  // Wake detection counters
  logic [WL-1:0] low_cnt;
  logic [WH-1:0] high_cnt;
  wire low_long  = (low_cnt >= WL'(WAKE_LOW_CYC));
  wire high_done = (high_cnt >= WH'(WAKE_HIGH_CYC));
  wire sleeping  = (mode == ccp_pkg::M_SLEEP) || (mode == ccp_pkg::M_IDLE);
  // wake on rise after long low
  wire wake_ev   = sleeping && sda_rise && low_long;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt  <= '0;
      high_cnt <= '0;
    end else begin
      if (!sleeping || sda_f) begin
        low_cnt <= '0;
      end else if (!low_long) begin
        low_cnt <= low_cnt + WL'(1);
      end
      if (mode != ccp_pkg::M_WAKE) begin
        high_cnt <= '0;
      end else if (!high_done) begin
        high_cnt <= high_cnt + WH'(1);
      end
    end
  end

  // Device mode transitions
  always_comb begin
    next_mode = mode;
    unique case (mode)
      ccp_pkg::M_SLEEP, ccp_pkg::M_IDLE: begin
        if (wake_ev) begin
          next_mode = ccp_pkg::M_WAKE;
        end
      end
      ccp_pkg::M_WAKE: begin
        if (high_done) begin
          next_mode = ccp_pkg::M_AWAKE;
        end
      end
      ccp_pkg::M_AWAKE: begin
        if (stop_ev && word_ok && word == ccp_pkg::WA_SLEEP) begin
          next_mode = ccp_pkg::M_SLEEP;
        end else if (stop_ev && word_ok && word == ccp_pkg::WA_IDLE) begin
          next_mode = ccp_pkg::M_IDLE;
        end else if (stop_ev && full_grp) begin
          next_mode = ccp_pkg::M_BUSY;
        end
      end
      ccp_pkg::M_BUSY: begin
        if (CMD_DONE) begin
          next_mode = ccp_pkg::M_AWAKE;
        end
      end
      default: next_mode = ccp_pkg::M_SLEEP;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode      <= ccp_pkg::M_SLEEP;
      CMD_START <= 1'b0;
      SLEEP_REQ <= 1'b0;
      IDLE_REQ  <= 1'b0;
    end else begin
      mode      <= next_mode;
      CMD_START <= awake && (next_mode == ccp_pkg::M_BUSY);
      SLEEP_REQ <= awake && (next_mode == ccp_pkg::M_SLEEP);
      IDLE_REQ  <= awake && (next_mode == ccp_pkg::M_IDLE);
    end
  end

  assign SDA_O  = 1'b0;
  assign SDA_OE = ack_drv;
  assign ASLEEP = (mode == ccp_pkg::M_SLEEP);
  assign IDLE   = (mode == ccp_pkg::M_IDLE);
  assign BUSY   = (mode == ccp_pkg::M_BUSY);
endmodule : ccp_port

/* File: tb/ccp_port_sva.sv */
// Concurrent checks on the command client port pins
`timescale 1ns/1ps
module ccp_port_sva (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESET_N,
  // Link pins
  input wire logic       SCL,
  input wire logic       SDA_O,
  input wire logic       SDA_OE,
  // Engine handshake and status
  input wire logic       CMD_START,
  input wire logic       CMD_DONE,
  input wire logic       SLEEP_REQ,
  input wire logic       IDLE_REQ,
  input wire logic [7:0] BUF_FILL,
  input wire logic       ASLEEP,
  input wire logic       IDLE,
  input wire logic       BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  open_drain_a: assert property (SDA_O == 1'b0)
    else $error("data pin driven high");
  ack_edge_a: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("ack changed with clock high");
  start_pulse_a: assert property (CMD_START |=> !CMD_START)
    else $error("start pulse too long");
  start_busy_a: assert property (CMD_START |-> ##[0:2] BUSY)
    else $error("start without busy");
  done_clear_a: assert property (BUSY && CMD_DONE |-> ##[1:3] (!BUSY && BUF_FILL == 8'h00))
    else $error("done did not empty buffer");
  fill_step_a: assert property ($changed(BUF_FILL) |->
    (BUF_FILL == 8'h00 || BUF_FILL == $past(BUF_FILL) + 8'h01))
    else $error("fill jumped");
  sleep_clear_a: assert property (SLEEP_REQ |-> ##[0:3] (ASLEEP && BUF_FILL == 8'h00))
    else $error("sleep not taken");
  idle_enter_a: assert property (IDLE_REQ |-> ##[0:3] IDLE)
    else $error("idle not taken");
  quiet_mode_a: assert property ((ASLEEP || IDLE || BUSY) |-> !SDA_OE)
    else $error("ack while not awake");
  one_mode_a: assert property ($onehot0({ASLEEP, IDLE, BUSY}))
    else $error("modes overlap");
endmodule : ccp_port_sva
bind ccp_port ccp_port_sva u_sva (.CLK(CLK), .RESET_N(RESET_N), .SCL(SCL), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .CMD_START(CMD_START), .CMD_DONE(CMD_DONE), .SLEEP_REQ(SLEEP_REQ),
  .IDLE_REQ(IDLE_REQ), .BUF_FILL(BUF_FILL), .ASLEEP(ASLEEP), .IDLE(IDLE), .BUSY(BUSY));

/* File: tb/ccp_host.sv */
// Bus host model driving the link clock and pulling the data line
`timescale 1ns/1ps
module ccp_host #(
  parameter realtime Q = 31.25
) (
  // Resolved data line
  input  wire logic SDA,
  // Link clock and data pull-down
  output logic      SCL,
  output logic      PULL
);
  initial begin
    SCL  = 1'b1;
    PULL = 1'b0;
  end
  task automatic start();
    PULL = 1'b0;
    #Q;
    SCL = 1'b1;
    #Q;
    PULL = 1'b1;
    #Q;
    SCL = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    PULL = 1'b1;
    #Q;
    SCL = 1'b1;
    #Q;
    PULL = 1'b0;
    #Q;
  endtask : stop
  task automatic xfer(input logic [7:0] b, output logic [7:0] rb, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      PULL = (i > 0) ? !b[i-1] : 1'b0;
      #Q;
      SCL = 1'b1;
      #Q;
      if (i > 0) rb[i-1] = SDA;
      else ack = !SDA;
      #Q;
      SCL = 1'b0;
      #Q;
    end
  endtask : xfer
  task automatic wake();
    PULL = 1'b1;
    #300;
    PULL = 1'b0;
  endtask : wake
  task automatic resync();
    logic [7:0] rb;
    logic       a;
    start();
    xfer(8'hFF, rb, a);
    start();
    stop();
  endtask : resync
endmodule : ccp_host

/* File: tb/tb_top.sv */
// Self-checking bench for the command client port
`timescale 1ns/1ps
module tb_top;
  logic        clk, reset_n, cmd_done, scl, pull, sda, sda_o, sda_oe, k;
  logic        cmd_start, sleep_req, idle_req, asleep, idle, busy;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data, fill, r, x;
  logic [7:0]  g[8];
  logic [31:0] seed;
  int          failures, check_count, starts, sleeps, idles, n, h;
  assign sda = !(pull || (sda_oe && !sda_o));
  ccp_port #(.FILT_CYC(1), .WAKE_LOW_CYC(20), .WAKE_HIGH_CYC(40)) DUT (.CLK(clk),
    .RESET_N(reset_n),
    .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .CMD_START(cmd_start),
    .CMD_DONE(cmd_done), .SLEEP_REQ(sleep_req), .IDLE_REQ(idle_req), .BUF_RD_ADDR(rd_addr),
    .BUF_RD_DATA(rd_data), .BUF_FILL(fill), .ASLEEP(asleep), .IDLE(idle), .BUSY(busy));
  ccp_host u_host (.SDA(sda), .SCL(scl), .PULL(pull));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (cmd_start) starts++;
    if (sleep_req) sleeps++;
    if (idle_req) idles++;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic addr_ok(input logic [7:0] a);
    return a[7:1] == ccp_pkg::BUS_ADDR_DFLT;
  endfunction : addr_ok
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic snd(input logic [7:0] b, input logic e);
    u_host.xfer(b, r, k);
    chk("ack", {7'h00, e}, {7'h00, k});
  endtask : snd
  task automatic wr(input logic [7:0] w);
    u_host.start();
    snd({ccp_pkg::BUS_ADDR_DFLT, ccp_pkg::RW_WRITE}, 1'b1);
    snd(w, w <= ccp_pkg::WA_LAST);
  endtask : wr
  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    seed = 32'h05A2;
    reset_n = 1'b0;
    cmd_done = 1'b0;
    rd_addr = 7'h00;
    cyc(6);
    reset_n = 1'b1;
    cyc(2);
    chk("asleep", 8'h01, {7'h00, asleep});
    u_host.wake();
    cyc(10);
    chk("asleep", 8'h00, {7'h00, asleep});
    cyc(70);
    for (int i = 0; i < 3; i++) begin
      x = (i == 0) ? 8'h72 : 8'(rnd());
      u_host.start();
      snd(x, addr_ok(x));
      u_host.stop();
    end
    n = 3 + int'(rnd() % 5);
    h = n / 2;
    g[0] = 8'(n);
    for (int i = 1; i < n; i++) g[i] = 8'(rnd());
    wr(ccp_pkg::WA_CMD);
    for (int i = 0; i < h; i++) snd(g[i], 1'b1);
    u_host.stop();
    cyc(20);
    chk("fill", 8'(h), fill);
    chk("busy", 8'h00, {7'h00, busy});
    u_host.start();
    snd(8'h71, 1'b0);
    u_host.stop();
    wr(ccp_pkg::WA_CMD);
    for (int i = h; i < n; i++) snd(g[i], 1'b1);
    snd(8'hA5, 1'b1);
    u_host.stop();
    cyc(20);
    chk("starts", 8'h01, 8'(starts));
    chk("busy", 8'h01, {7'h00, busy});
    chk("fill", 8'(n), fill);
    for (int i = 0; i < n; i++) begin
      rd_addr = 7'(i);
      cyc(2);
      chk("buf", g[i], rd_data);
    end
    u_host.start();
    snd(8'h70, 1'b0);
    u_host.stop();
    cmd_done = 1'b1;
    cyc(1);
    cmd_done = 1'b0;
    cyc(5);
    chk("busy", 8'h00, {7'h00, busy});
    u_host.start();
    snd(8'h71, 1'b1);
    u_host.xfer(8'hFF, r, k);
    chk("read", 8'hFF, r);
    u_host.stop();
    wr(ccp_pkg::WA_CMD);
    snd(8'h40, 1'b1);
    snd(8'h41, 1'b1);
    u_host.stop();
    u_host.resync();
    u_host.start();
    snd(8'h71, 1'b0);
    u_host.stop();
    wr(ccp_pkg::WA_RESET);
    u_host.stop();
    u_host.start();
    snd(8'h71, 1'b1);
    u_host.stop();
    wr(ccp_pkg::WA_CMD);
    snd(8'h3C, 1'b1);
    u_host.stop();
    rd_addr = 7'h00;
    cyc(2);
    chk("buf0", 8'h3C, rd_data);
    wr(8'(4 + rnd() % 252));
    u_host.stop();
    wr(ccp_pkg::WA_IDLE);
    u_host.stop();
    cyc(20);
    chk("idle", 8'h01, {7'h00, idle});
    chk("idles", 8'h01, 8'(idles));
    u_host.start();
    snd(8'h70, 1'b0);
    u_host.stop();
    u_host.wake();
    cyc(70);
    chk("idle", 8'h00, {7'h00, idle});
    chk("kept", 8'h3C, rd_data);
    chk("fill", 8'h01, fill);
    wr(ccp_pkg::WA_SLEEP);
    u_host.stop();
    cyc(20);
    chk("asleep", 8'h01, {7'h00, asleep});
    chk("fill", 8'h00, fill);
    chk("sleeps", 8'h01, 8'(sleeps));
    u_host.start();
    snd(8'h70, 1'b0);
    u_host.stop();
    give_verdict();
  end
endmodule : tb_top
